// ===== lvsc_defs.svh
// Offsets, field positions, reset values and key codes of the stop-mode controller.
// Assumes inclusion by bare name from the controller and bench modules.
`ifndef LVSC_DEFS_SVH
`define LVSC_DEFS_SVH

`define LVSC_OFF_PROTECT   8'h00
`define LVSC_OFF_VOLTAGE   8'h04
`define LVSC_OFF_MODE      8'h08
`define LVSC_OFF_CONTROL   8'h0C
`define LVSC_OFF_CLKSEL    8'h10
`define LVSC_OFF_STATUS    8'h14

`define LVSC_KEY_UNLOCK    8'hC9
`define LVSC_KEY_LOCK      8'h00
`define LVSC_VOLT_LOW      8'h01
`define LVSC_VOLT_RST      8'h00
`define LVSC_MODE_RST      2'h0
`define LVSC_STOP_BIT      1

`define LVSC_CS_TMR_DIV8   0
`define LVSC_CS_TMR_SUB    1
`define LVSC_CS_WCH_SUB    2
`define LVSC_CS_SUB_USED   3
`define LVSC_CS_WDT_OSC    4
`define LVSC_CS_WDT_SUB    5
`define LVSC_CS_CSI0_EXT   6
`define LVSC_CS_UART0_EXT  9
`define LVSC_CLKSEL_RST    10'h000

`endif

// ===== lvsc_pkg.sv
// Types shared by the stop-mode controller.
// Assumes lvsc_defs.svh holds the numeric constants.
package lvsc_pkg;
  typedef enum logic [1:0] {LVSC_RUN, LVSC_STOPPED} lvsc_state_t;
endpackage

// ===== lvsc_bus_if.sv
// Interface carrying decoded register writes from the bus slave to the core.
// Assumes a single clock domain.
`timescale 1ns/1ns
`default_nettype none
interface lvsc_bus_if;
  logic        wr_en;
  logic [7:0]  wr_addr;
  logic [15:0] wr_data;
  modport slave (output wr_en, output wr_addr, output wr_data);
  modport core  (input wr_en, input wr_addr, input wr_data);
endinterface
`default_nettype wire

// ===== lvsc_axi_slave.sv
// AXI4-Lite write path: pairs address and data, issues one write strobe.
// Assumes one outstanding write; reads are served by the top module.
`timescale 1ns/1ns
`default_nettype none
module lvsc_axi_slave (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // Write channels
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic             bvalid,
  input  wire logic        bready,
  // Decoded write
  lvsc_bus_if.slave        wb
);
  logic        aw_have_r;
  logic        w_have_r;
  logic [7:0]  aw_r;
  logic [15:0] w_r;
  logic        bvalid_r;
  wire         aw_take = awvalid & awready;
  wire         w_take  = wvalid & wready;
  wire         fire    = (aw_have_r | aw_take) & (w_have_r | w_take) & ~bvalid_r & ce;
  // Lanes 0 and 1 carry register data; a disabled lane writes zeros
  wire  [15:0] w_lanes = {wstrb[1] ? wdata[15:8] : 8'h00, wstrb[0] ? wdata[7:0] : 8'h00};

  // Accept each channel once until the response drains
  assign awready    = ce & ~aw_have_r & ~bvalid_r;
  assign wready     = ce & ~w_have_r & ~bvalid_r;
  assign bvalid     = bvalid_r;
  assign wb.wr_en   = fire;
  assign wb.wr_addr = aw_have_r ? aw_r : awaddr;
  // Selects above bit 7 need the second lane, so two lanes are passed on
  assign wb.wr_data = w_have_r ? w_r : w_lanes;

  // Hold each half until both are present
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      aw_r      <= 8'h00;
      w_r       <= 16'h0000;
      bvalid_r  <= 1'b0;
    end else if (ce) begin
      if (fire) begin
        aw_have_r <= 1'b0;
        w_have_r  <= 1'b0;
        bvalid_r  <= 1'b1;
      end else begin
        if (aw_take) begin
          aw_have_r <= 1'b1;
          aw_r      <= awaddr;
        end
        if (w_take) begin
          w_have_r <= 1'b1;
          w_r      <= w_lanes;
        end
        if (bvalid_r && bready) begin
          bvalid_r <= 1'b0;
        end
      end
    end
  end
endmodule // lvsc_axi_slave
`default_nettype wire

// ===== lvsc_ctrl.sv
// Stop / low-voltage stop controller: protected regulator setting, stop entry,
// pending-interrupt release and per-peripheral run gating while stopped.
// Assumes software on the CPU follows the entry order; one clock, AXI4-Lite.
//
// Behaviour
// [R1] Software runs the whole low-voltage entry sequence in order, main clock running.
// [R2] External serial and UART baud clocks are stopped before low-voltage stop.
// [R3] Software disables DMA before changing the regulator setting.
// [R4] Software masks interrupts, clears both NMI edge enables, silences watchdog interrupt.
// [R5] Writing C9H to the protect register unlocks the next voltage write.
// [R6] Voltage write of 01H selects low-voltage; output stays normal until stop.
// [R7] Software writes 00H to the protect register to relock it.
// [R8] Software may re-enable DMA and interrupts any time after relocking.
// [R9] Stop entered when mode field is 01 or 11 and stop bit written 1.
// [R10] Regulator output is lowered while stopped with the low setting active.
// [R11] Software places five or more no-ops after the stop-triggering store.
// [R12] A pending unmasked interrupt at stop request releases stop immediately.
// [R13] CPU, DMA and interrupt controller halt; release detection stays alive.
// [R14] Interval timer runs while stopped only on oscillator/8 or subclock.
// [R15] Watch timer runs while stopped only with subclock used and selected.
// [R16] Watchdog keeps counting on internal oscillator or subclock.
// [R17] Serial channels 0-2 run on external clock; inter-IC channels halt.
// [R18] UARTs halt; first UART runs if its external baud clock selected.
// [R19] A/D halts with result undefined; D/A output goes high impedance.
// [R20] Real-time output halts holding outputs; ports keep prior states.
// [R21] CPU registers, status and memory are preserved across stop.
// [R22] D/A output is high impedance while stopped, not held.
// [R23] Voltage write not directly after the unlock write is ignored.
//
// The AXI4-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "lvsc_defs.svh"
module lvsc_ctrl
  import lvsc_pkg::*;
#(
  parameter int CSI_N  = 3,
  parameter int UART_N = 3,
  parameter int IIC_N  = 2
) (
  // Clock, enable, reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  // AXI4-Lite slave
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Wake sources
  input  wire logic              irq_pending,
  input  wire logic              wake_req,
  // Regulator and core gating
  output logic                   regulator_low,
  output logic                   stopped,
  output logic                   cpu_run,
  output logic                   dma_run,
  output logic                   intc_run,
  output logic                   wake_detect_en,
  output logic                   main_osc_en,
  // Peripheral run enables while stopped
  output logic                   interval_timer_run,
  output logic                   watch_timer_run,
  output logic                   watchdog_run,
  output logic [CSI_N-1:0]       csi_run,
  output logic [IIC_N-1:0]       iic_run,
  output logic [UART_N-1:0]      uart_run,
  output logic                   adc_run,
  output logic                   adc_result_valid,
  output logic                   dac_oe,
  output logic                   realtime_output_run,
  output logic                   realtime_output_hold,
  output logic                   port_hold,
  output logic                   state_retain
);
  lvsc_bus_if bus ();

  lvsc_state_t state_r;
  lvsc_state_t state_nxt;
  logic        unlock_r;
  logic [7:0]  volt_r;
  logic [1:0]  mode_r;
  logic [9:0]  clksel_r;
  logic        adc_valid_r;
  logic        arv_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;

  // Decode used for both write strobes and read mux
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  lvsc_axi_slave u_axi (
    .clk     (clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .wb      (bus.slave)
  );

  // Write decode
  wire wr_prot = bus.wr_en & hit(bus.wr_addr, `LVSC_OFF_PROTECT);
  wire wr_volt = bus.wr_en & hit(bus.wr_addr, `LVSC_OFF_VOLTAGE);
  wire wr_mode = bus.wr_en & hit(bus.wr_addr, `LVSC_OFF_MODE);
  wire wr_ctrl = bus.wr_en & hit(bus.wr_addr, `LVSC_OFF_CONTROL);
  wire wr_csel = bus.wr_en & hit(bus.wr_addr, `LVSC_OFF_CLKSEL);
  wire wr_known = wr_prot | wr_volt | wr_mode | wr_ctrl | wr_csel;
  // [R9] stop trigger decode
  wire stop_req = wr_ctrl & bus.wr_data[`LVSC_STOP_BIT] & mode_r[0];
  // [R12] pending request cancels entry
  wire stop_go  = stop_req & ~irq_pending;
  wire is_stop  = (state_r == LVSC_STOPPED);
  wire volt_low = (volt_r == `LVSC_VOLT_LOW);
  logic bresp_err_r;

  // Unmapped writes answer SLVERR; the response sits with bvalid
  assign s_axi_bresp = bresp_err_r ? 2'b10 : 2'b00;

  // State sequencing: the wake path must stay alive while stopped
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      LVSC_RUN:     if (stop_go) state_nxt = LVSC_STOPPED;
      LVSC_STOPPED: if (irq_pending || wake_req) state_nxt = LVSC_RUN;
      default:      state_nxt = LVSC_RUN;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= LVSC_RUN;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  // Protect key: any write to another register also drops the unlock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      unlock_r <= 1'b0;
    end else if (ce && bus.wr_en) begin
      // [R5] key unlock
      unlock_r <= wr_prot && (bus.wr_data[7:0] == `LVSC_KEY_UNLOCK);
    end
  end

  // Regulator voltage setting, write only when unlocked
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      volt_r <= `LVSC_VOLT_RST;
    end else if (ce && wr_volt && unlock_r) begin
      // [R23] guarded write
      volt_r <= bus.wr_data[7:0];
    end
  end

  // Mode field and clock-source selections
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r   <= `LVSC_MODE_RST;
      clksel_r <= `LVSC_CLKSEL_RST;
    end else if (ce) begin
      if (wr_mode) mode_r <= bus.wr_data[1:0];
      if (wr_csel) clksel_r <= bus.wr_data[9:0];
    end
  end

  // A/D result invalid after any stop until a new conversion is flagged
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      adc_valid_r <= 1'b0;
    end else if (ce) begin
      // [R19] result undefined
      if (stop_go) adc_valid_r <= 1'b0;
      else if (wr_ctrl && bus.wr_data[0]) adc_valid_r <= 1'b1;
    end
  end

  // Read path: one word, registered, held until rready
  wire [31:0] rd_mux =
    hit(s_axi_araddr, `LVSC_OFF_PROTECT) ? {31'h0, unlock_r} :
    hit(s_axi_araddr, `LVSC_OFF_VOLTAGE) ? {24'h0, volt_r} :
    hit(s_axi_araddr, `LVSC_OFF_MODE)    ? {30'h0, mode_r} :
    hit(s_axi_araddr, `LVSC_OFF_CLKSEL)  ? {22'h0, clksel_r} :
    hit(s_axi_araddr, `LVSC_OFF_STATUS)  ? {29'h0, adc_valid_r, regulator_low, is_stop} : 32'h0;
  wire rd_known = hit(s_axi_araddr, `LVSC_OFF_PROTECT) | hit(s_axi_araddr, `LVSC_OFF_VOLTAGE) |
                  hit(s_axi_araddr, `LVSC_OFF_MODE) | hit(s_axi_araddr, `LVSC_OFF_CLKSEL) |
                  hit(s_axi_araddr, `LVSC_OFF_STATUS) | hit(s_axi_araddr, `LVSC_OFF_CONTROL);
  assign s_axi_arready = ce & ~arv_r;
  assign s_axi_rvalid  = arv_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arv_r       <= 1'b0;
      rdata_r     <= 32'h0;
      rresp_r     <= 2'b00;
      bresp_err_r <= 1'b0;
    end else if (ce) begin
      if (s_axi_arvalid && !arv_r) begin
        arv_r   <= 1'b1;
        rdata_r <= rd_mux;
        rresp_r <= rd_known ? 2'b00 : 2'b10;
      end else if (arv_r && s_axi_rready) begin
        arv_r <= 1'b0;
      end
      if (bus.wr_en) bresp_err_r <= ~wr_known;
    end
  end

  // [R6] normal until stop
  // [R10] low regulator only while stopped
  assign regulator_low  = is_stop & volt_low;
  assign stopped        = is_stop;
  // [R13] core halts, wake detect stays
  assign cpu_run        = ~is_stop;
  assign dma_run        = ~is_stop;
  assign intc_run       = ~is_stop;
  assign wake_detect_en = 1'b1;
  assign main_osc_en    = ~is_stop;
  // [R14] interval timer source
  assign interval_timer_run = ~is_stop | clksel_r[`LVSC_CS_TMR_DIV8] | clksel_r[`LVSC_CS_TMR_SUB];
  // [R15] watch timer on subclock
  assign watch_timer_run = ~is_stop | (clksel_r[`LVSC_CS_WCH_SUB] & clksel_r[`LVSC_CS_SUB_USED]);
  // [R16] watchdog source
  assign watchdog_run = ~is_stop | clksel_r[`LVSC_CS_WDT_OSC] | clksel_r[`LVSC_CS_WDT_SUB];

  // [R17] serial channels on external clock
  genvar gi;
  generate
    for (gi = 0; gi < CSI_N; gi++) begin : g_csi
      assign csi_run[gi] = ~is_stop | clksel_r[`LVSC_CS_CSI0_EXT + gi];
    end
    for (gi = 0; gi < IIC_N; gi++) begin : g_iic
      assign iic_run[gi] = ~is_stop;
    end
    // [R18] only first UART may continue
    for (gi = 0; gi < UART_N; gi++) begin : g_uart
      if (gi == 0) begin : g_first
        assign uart_run[gi] = ~is_stop | clksel_r[`LVSC_CS_UART0_EXT];
      end else begin : g_rest
        assign uart_run[gi] = ~is_stop;
      end
    end
  endgenerate

  // [R19] A/D halts while stopped
  assign adc_run          = ~is_stop;
  assign adc_result_valid = adc_valid_r & ~is_stop;
  // [R22] D/A released to high impedance
  assign dac_oe           = ~is_stop;
  // [R20] outputs held, ports retained
  assign realtime_output_run  = ~is_stop;
  assign realtime_output_hold = is_stop;
  assign port_hold            = is_stop;
  // [R21] state retained, no reset on stop
  assign state_retain         = 1'b1;

  // Assertions
  AST_REG_LOW: assert property (@(posedge clk) disable iff (!rst_n)
    regulator_low |-> (is_stop && volt_r == 8'h01)) else $error("regulator low outside stop"); // [R10]
  AST_NO_LOW_RUN: assert property (@(posedge clk) disable iff (!rst_n)
    !is_stop |-> !regulator_low) else $error("regulator lowered while running"); // [R6]
  AST_UNLOCK: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && wr_prot && bus.wr_data[7:0] == 8'hC9) |=> unlock_r) else $error("unlock key not taken"); // [R5]
  AST_GUARD: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && wr_volt && !unlock_r) |=> $stable(volt_r)) else $error("locked voltage write changed setting"); // [R23]
  AST_ENTER: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && !is_stop && wr_ctrl && bus.wr_data[1] && mode_r[0] && !irq_pending) |=> is_stop)
    else $error("stop not entered"); // [R9]
  AST_MODE_GATE: assert property (@(posedge clk) disable iff (!rst_n)
    (!is_stop && !mode_r[0]) |=> !is_stop) else $error("stop entered with wrong mode"); // [R9]
  AST_PEND: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && is_stop && irq_pending) |=> !is_stop) else $error("pending interrupt did not release"); // [R12]
  AST_CORE: assert property (@(posedge clk) disable iff (!rst_n)
    is_stop |-> (!cpu_run && !dma_run && wake_detect_en)) else $error("core not halted"); // [R13]
  AST_DAC: assert property (@(posedge clk) disable iff (!rst_n)
    is_stop |-> !dac_oe && !adc_result_valid) else $error("converters not parked"); // [R22]
  AST_CANCEL: assert property (@(posedge clk) disable iff (!rst_n) // [R12]
    (!is_stop && irq_pending) |=> !is_stop) else $error("stop held with interrupt pending");
  AST_UART: assert property (@(posedge clk) disable iff (!rst_n)
    (is_stop && !clksel_r[9]) |-> !uart_run[0]) else $error("first uart running without ext clock"); // [R18]
  COV_LVSTOP: cover property (@(posedge clk) disable iff (!rst_n) $rose(regulator_low));
  COV_STOP_NORMAL: cover property (@(posedge clk) disable iff (!rst_n) $rose(is_stop) && !volt_low);
  COV_CANCEL: cover property (@(posedge clk) disable iff (!rst_n) stop_req && irq_pending);
  COV_WAKE: cover property (@(posedge clk) disable iff (!rst_n) $fell(is_stop));
endmodule // lvsc_ctrl
`default_nettype wire

// ===== lvsc_ctrl_bench.sv
// Self-checking bench for the stop / low-voltage stop controller.
// Assumes the package, interface and design modules are compiled first; ce stays high except during the freeze step.
`timescale 1ns/1ns
`default_nettype none
`include "lvsc_defs.svh"
`define LVSC_CHK(got, exp) begin checked++; if ((got) !== (exp)) begin err_total++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module lvsc_ctrl_bench;
  typedef struct packed {logic [9:0] cs; logic [1:0] mode; logic [7:0] exp;} lvsc_row_t;
  // Bus side
  logic        clk, rst_n, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, iic_run;
  // Wake and gating side
  logic        irq_pending, wake_req, regulator_low, stopped, cpu_run, dma_run, intc_run;
  logic        wake_detect_en, main_osc_en, interval_timer_run, watch_timer_run, watchdog_run;
  logic        adc_run, adc_result_valid, dac_oe, realtime_output_run, realtime_output_hold;
  logic        port_hold, state_retain;
  logic [2:0]  csi_run, uart_run;
  int          err_total = 0;
  int          checked = 0;
  // Clock select, mode, expected {stopped, interval, watch, watchdog, csi[2:0], uart0}
  lvsc_row_t   rows [13] = '{'{10'h000, 2'h1, 8'h80}, '{10'h001, 2'h3, 8'hC0}, '{10'h00A, 2'h1, 8'hC0},
                             '{10'h004, 2'h1, 8'h80}, '{10'h00C, 2'h1, 8'hA0}, '{10'h010, 2'h1, 8'h90},
                             '{10'h028, 2'h1, 8'h90}, '{10'h040, 2'h1, 8'h82}, '{10'h080, 2'h1, 8'h84},
                             '{10'h100, 2'h1, 8'h88}, '{10'h200, 2'h1, 8'h81}, '{10'h3FF, 2'h0, 8'h7F},
                             '{10'h3FF, 2'h2, 8'h7F}};

  lvsc_ctrl dut (.clk, .rst_n, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .irq_pending, .wake_req, .regulator_low, .stopped, .cpu_run, .dma_run, .intc_run,
    .wake_detect_en, .main_osc_en, .interval_timer_run, .watch_timer_run, .watchdog_run, .csi_run,
    .iic_run, .uart_run, .adc_run, .adc_result_valid, .dac_oe, .realtime_output_run,
    .realtime_output_hold, .port_hold, .state_retain);

  // 125 MHz clock
  always #4 clk = ~clk;

  // Verdict and end of run, shared with the watchdog
  task automatic end_of_test();
    if (err_total == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Write one register; handshakes are sampled at the settled negedge before the taking edge
  task automatic axi_wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
    logic ta, tw, tb, done;
    logic [1:0] r;
    done = 1'h0;
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'h1;
    s_axi_wdata   <= {16'h0000, d};
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    while (!done) begin
      @(negedge clk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid & s_axi_bready;
      r  = s_axi_bresp;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      if (tb) begin
        s_axi_bready <= 1'h0;
        done = 1'h1;
      end
    end
    // Extra edge so the next request never re-drives a strobe in the same step
    @(posedge clk);
    `LVSC_CHK(r, er)
  endtask

  // Read one register and compare the whole word, upper lanes zero, when the answer is OKAY
  task automatic axi_rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
    logic ta, tr, done;
    logic [31:0] d;
    logic [1:0] r;
    done = 1'h0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    while (!done) begin
      @(negedge clk);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid & s_axi_rready;
      d  = s_axi_rdata;
      r  = s_axi_rresp;
      @(posedge clk);
      if (ta) s_axi_arvalid <= 1'h0;
      if (tr) begin
        s_axi_rready <= 1'h0;
        done = 1'h1;
      end
    end
    @(posedge clk);
    `LVSC_CHK(r, er)
    if (er == 2'h0) `LVSC_CHK(d, {24'h000000, ed})
  endtask

  // Core and peripheral gating that follows the stopped state alone
  task automatic chk_gate(input logic s);
    `LVSC_CHK({stopped, cpu_run, dma_run, intc_run, main_osc_en, adc_run, dac_oe, realtime_output_run,
      realtime_output_hold, port_hold, wake_detect_en, state_retain}, {s, {7{~s}}, {2{s}}, 2'h3})
    `LVSC_CHK({iic_run, uart_run[2:1]}, s ? 4'h0 : 4'hF)
  endtask

  // Outputs held at their idle values while reset is asserted
  task automatic chk_rst();
    @(negedge clk);
    `LVSC_CHK({stopped, regulator_low, dac_oe, cpu_run, s_axi_bvalid, s_axi_rvalid}, 6'h0C)
  endtask

  // Hang guard, well beyond the few hundred cycles of the sequence
  initial begin
    #400000;
    err_total++;
    end_of_test();
  end

  // Main sequence
  initial begin
    clk = 1'h0; rst_n = 1'h0; ce = 1'h1; irq_pending = 1'h0; wake_req = 1'h0;
    s_axi_awaddr = 8'h00; s_axi_awvalid = 1'h0; s_axi_wdata = 32'h00000000; s_axi_wstrb = 4'hF;
    s_axi_wvalid = 1'h0; s_axi_bready = 1'h0; s_axi_araddr = 8'h00; s_axi_arvalid = 1'h0;
    s_axi_rready = 1'h0;
    chk_rst();
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    // Table: each mode and clock-source choice, stop request, release by wake_req
    foreach (rows[i]) begin
      axi_wr(`LVSC_OFF_CLKSEL, {6'h00, rows[i].cs}, 2'h0);
      axi_wr(`LVSC_OFF_MODE, {14'h0000, rows[i].mode}, 2'h0);
      axi_wr(`LVSC_OFF_CONTROL, 16'h0002, 2'h0);
      @(negedge clk);
      `LVSC_CHK({stopped, interval_timer_run, watch_timer_run, watchdog_run, csi_run, uart_run[0]},
        rows[i].exp)
      chk_gate(rows[i].exp[7]);
      `LVSC_CHK(regulator_low, 1'h0)
      @(posedge clk);
      wake_req <= 1'h1;
      @(posedge clk);
      wake_req <= 1'h0;
      @(negedge clk);
      `LVSC_CHK(stopped, 1'h0)
      @(posedge clk);
    end
    // Voltage writes without a directly preceding unlock are dropped
    axi_wr(`LVSC_OFF_VOLTAGE, {8'h00, `LVSC_VOLT_LOW}, 2'h0);
    axi_rd(`LVSC_OFF_VOLTAGE, `LVSC_VOLT_RST, 2'h0);
    axi_wr(`LVSC_OFF_PROTECT, {8'h00, `LVSC_KEY_UNLOCK}, 2'h0);
    axi_rd(`LVSC_OFF_PROTECT, 8'h01, 2'h0);
    axi_wr(`LVSC_OFF_MODE, 16'h0001, 2'h0);
    axi_wr(`LVSC_OFF_VOLTAGE, {8'h00, `LVSC_VOLT_LOW}, 2'h0);
    axi_rd(`LVSC_OFF_VOLTAGE, `LVSC_VOLT_RST, 2'h0);
    // whole entry in order, main clock running
    axi_wr(`LVSC_OFF_CLKSEL, 16'h0000, 2'h0);
    // no DMA or interrupt request during regulator steps
    axi_wr(`LVSC_OFF_PROTECT, {8'h00, `LVSC_KEY_UNLOCK}, 2'h0);
    axi_wr(`LVSC_OFF_VOLTAGE, {8'h00, `LVSC_VOLT_LOW}, 2'h0);
    axi_wr(`LVSC_OFF_PROTECT, {8'h00, `LVSC_KEY_LOCK}, 2'h0);
    axi_rd(`LVSC_OFF_PROTECT, 8'h00, 2'h0);
    axi_rd(`LVSC_OFF_VOLTAGE, `LVSC_VOLT_LOW, 2'h0);
    axi_wr(`LVSC_OFF_CONTROL, 16'h0001, 2'h0);
    axi_rd(`LVSC_OFF_STATUS, 8'h04, 2'h0);
    @(negedge clk);
    `LVSC_CHK(regulator_low, 1'h0)
    @(posedge clk);
    axi_wr(`LVSC_OFF_CONTROL, 16'h0002, 2'h0);
    // bus idle after the stop store
    repeat (5) @(posedge clk);
    axi_rd(`LVSC_OFF_STATUS, 8'h03, 2'h0);
    @(negedge clk);
    `LVSC_CHK({regulator_low, adc_result_valid, csi_run, uart_run[0]}, 6'h20)
    chk_gate(1'h1);
    // interrupts back after relock; one releases stop and the stale A/D result stays gone
    @(posedge clk);
    irq_pending <= 1'h1;
    @(posedge clk);
    @(negedge clk);
    `LVSC_CHK({stopped, regulator_low}, 2'h0)
    @(posedge clk);
    axi_rd(`LVSC_OFF_STATUS, 8'h00, 2'h0);
    // Stop requested with the interrupt still pending never holds
    axi_wr(`LVSC_OFF_CONTROL, 16'h0002, 2'h0);
    @(negedge clk);
    `LVSC_CHK({stopped, cpu_run}, 2'h1)
    @(posedge clk);
    irq_pending <= 1'h0;
    // Unmapped address answers with an error and changes nothing
    axi_wr(8'h18, 16'h0055, 2'h2);
    axi_rd(8'h18, 8'h00, 2'h2);
    axi_rd(`LVSC_OFF_VOLTAGE, `LVSC_VOLT_LOW, 2'h0);
    // Stop again, then freeze everything with ce low while a release is requested
    axi_wr(`LVSC_OFF_CONTROL, 16'h0002, 2'h0);
    @(negedge clk);
    `LVSC_CHK({stopped, regulator_low}, 2'h3)
    @(posedge clk);
    ce       <= 1'h0;
    wake_req <= 1'h1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    `LVSC_CHK({stopped, s_axi_awready, s_axi_arready}, 3'h4)
    @(posedge clk);
    ce <= 1'h1;
    @(posedge clk);
    wake_req <= 1'h0;
    @(negedge clk);
    `LVSC_CHK(stopped, 1'h0)
    @(posedge clk);
    // Reset in mid-stop clears the state and the registers
    axi_wr(`LVSC_OFF_CONTROL, 16'h0002, 2'h0);
    @(negedge clk);
    `LVSC_CHK({stopped, regulator_low}, 2'h3)
    @(posedge clk);
    rst_n <= 1'h0;
    chk_rst();
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    axi_rd(`LVSC_OFF_VOLTAGE, `LVSC_VOLT_RST, 2'h0);
    axi_rd(`LVSC_OFF_MODE, 8'h00, 2'h0);
    axi_rd(`LVSC_OFF_CLKSEL, 8'h00, 2'h0);
    axi_rd(`LVSC_OFF_STATUS, 8'h00, 2'h0);
    end_of_test();
  end
endmodule // lvsc_ctrl_bench
`undef LVSC_CHK
`default_nettype wire
